// ==== bench/aot_programmer.sv ====
// Model of the external programmer that loads the transfer configuration.
// Assumes the plain register port of the bank and a shared clock.
`timescale 1ns/100ps
`include "aot_cfg.svh"
module aot_programmer (
	// Clock.
	input  wire logic        clk,
	// Register port.
	output logic      [3:0]  regAddr,
	output logic      [15:0] regWrData,
	output logic             regWr,
	output logic             regRd,
	input  wire logic [15:0] regRdData
);
	initial begin
		regAddr = 4'h0;
		regWrData = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk) begin
			regAddr <= a;
			regWrData <= d;
			regWr <= 1'b1;
		end
		@(posedge clk) begin
			regWr <= 1'b0;
			regWrData <= ~d;
		end
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk) begin
			regAddr <= a;
			regRd <= 1'b1;
		end
		@(posedge clk) regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	// Write followed by a read of the same register with no gap between strobes.
	task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
		@(posedge clk) begin
			regAddr <= a;
			regWrData <= d;
			regWr <= 1'b1;
		end
		@(posedge clk) begin
			regWr <= 1'b0;
			regRd <= 1'b1;
		end
		@(posedge clk) regRd <= 1'b0;
		#1 q = regRdData;
	endtask
	// Levels must stay within 256 to 4864; undefined bits are written as zero.
	task automatic load(input int fl, input int ce, input int rng, input int zr,
			input logic [2:0] opt);
		real m;
		int s;
		int sw;
		m = (ce - fl) / 8192.0 * 180.0 / rng;
		s = $rtoi(m * 16384.0 + 0.5);
		sw = $rtoi(0.5 * (1.0 + (ce - fl) / 8192.0 / m) * 1024.0);
		if (sw > 1023) begin
			sw = 1023;
		end
		wr(`AOT_ADDR_ZERO, zr[15:0]);
		wr(`AOT_ADDR_SW_HIGH, {sw[9:0], s[18:13]});
		wr(`AOT_ADDR_OPT_LOW, {opt, s[12:0]});
		wr(`AOT_ADDR_FLOOR, {3'h0, fl[12:0]});
		wr(`AOT_ADDR_CEIL, {3'h0, ce[12:0]});
	endtask
endmodule

// ==== bench/aot_transfer_bank_tb.sv ====
// Self-checking bench of the transfer configuration bank.
// Assumes the programmer model drives the register port.
`timescale 1ns/100ps
`include "aot_cfg.svh"
module aot_transfer_bank_tb;
	logic        clk;
	logic        rst;
	logic [3:0]  regAddr;
	logic [15:0] regWrData;
	logic        regWr;
	logic        regRd;
	logic [15:0] regRdData;
	logic [15:0] angle;
	logic        angleValid;
	logic [12:0] dacCode;
	logic        dacValid;
	logic [1:0]  diagLevel;
	logic [15:0] rv;
	int          fails;
	int          compares;

	aot_transfer_bank aot_transfer_bank_i (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.angle(angle), .angleValid(angleValid), .dacCode(dacCode), .dacValid(dacValid),
		.diagLevel(diagLevel));
	aot_programmer aot_programmer_i (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData));

	always #20 clk = ~clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic samp2(input logic [15:0] a0, input logic [15:0] e0,
			input logic [15:0] a1, input logic [15:0] e1);
		@(posedge clk) begin
			angle <= a0;
			angleValid <= 1'b1;
		end
		@(posedge clk) angle <= a1;
		#1 check(dacCode, e0);
		check(dacValid, 1'b1);
		@(posedge clk) angleValid <= 1'b0;
		#1 check(dacCode, e1);
		check(dacValid, 1'b1);
		@(posedge clk) #1 check(dacValid, 1'b0);
	endtask
	task automatic t_reset;
		check(dacCode, 16'h0100);
		aot_programmer_i.rd(`AOT_ADDR_ZERO, rv);
		check(rv, 16'h0000);
		aot_programmer_i.rd(`AOT_ADDR_SW_HIGH, rv);
		check(rv, 16'hffc1);
		aot_programmer_i.rd(`AOT_ADDR_OPT_LOW, rv);
		check(rv, 16'h0400);
		aot_programmer_i.rd(`AOT_ADDR_FLOOR, rv);
		check(rv, 16'h0100);
		aot_programmer_i.rd(`AOT_ADDR_CEIL, rv);
		check(rv, 16'h1300);
		aot_programmer_i.rd(4'h0, rv);
		check(rv, 16'h0000);
		@(posedge clk) #1 check(regRdData, 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_bits;
		aot_programmer_i.wr(`AOT_ADDR_FLOOR, 16'he200);
		aot_programmer_i.rd(`AOT_ADDR_FLOOR, rv);
		check(rv, 16'h0200);
		aot_programmer_i.wr(`AOT_ADDR_CEIL, 16'hf300);
		aot_programmer_i.rd(`AOT_ADDR_CEIL, rv);
		check(rv, 16'h1300);
		aot_programmer_i.wr_rd(`AOT_ADDR_SW_HIGH, 16'h1234, rv);
		check(rv, 16'h1234);
		$display("test bits done");
	endtask
	task automatic t_rise;
		aot_programmer_i.load(256, 4864, 180, 0, 3'h0);
		samp2(16'h8000, 16'd2560, 16'hffff, 16'd4863);
		samp2(16'h0000, 16'h0100, 16'h4000, 16'h0580);
		$display("test rise done");
	endtask
	task automatic t_switch;
		aot_programmer_i.load(256, 4864, 90, 0, 3'h0);
		aot_programmer_i.rd(`AOT_ADDR_SW_HIGH, rv);
		check(rv, 16'hc002);
		samp2(16'hc000, 16'd4864, 16'hc040, 16'd256);
		aot_programmer_i.wr(`AOT_ADDR_CEIL, 16'h0800);
		samp2(16'h8000, 16'd2048, 16'h4000, 16'd2048);
		$display("test switch done");
	endtask
	task automatic t_fall;
		aot_programmer_i.load(256, 4864, 90, 16'h4000, 3'h3);
		samp2(16'h8000, 16'd2560, 16'h0100, 16'd4864);
		samp2(16'h4000, 16'h1300, 16'hc000, 16'h0100);
		check(diagLevel, 2'h1);
		$display("test fall done");
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		angle = 16'h0000;
		angleValid = 1'b0;
		fails = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_bits();
		t_rise();
		t_switch();
		t_fall();
		conclude();
	end
	initial begin
		#100000;
		fails++;
		conclude();
	end
endmodule

// ==== include/aot_cfg.svh ====
// Constants of the angle-to-output transfer configuration bank.
// Assumes inclusion by bare name from the package and design files.
`ifndef AOT_CFG_SVH
`define AOT_CFG_SVH
`define AOT_ADDR_ZERO       4'h8
`define AOT_ADDR_SW_HIGH    4'h9
`define AOT_ADDR_OPT_LOW    4'ha
`define AOT_ADDR_FLOOR      4'hb
`define AOT_ADDR_CEIL       4'hc
`define AOT_RST_ZERO        16'h0000
`define AOT_RST_SW_HIGH     16'hffc1
`define AOT_RST_OPT_LOW     16'h0400
`define AOT_RST_FLOOR       16'h0100
`define AOT_RST_CEIL        16'h1300
`define AOT_SW_LSB          6
`define AOT_HIGH_MSB        5
`define AOT_DIAG_LSB        14
`define AOT_SLOPE_BIT       13
`define AOT_LOW_MSB         12
`define AOT_LEVEL_MSB       12
`define AOT_DAC_FULL        14'h1400
`define AOT_DAC_MIN         13'h0100
`define AOT_DAC_MAX         13'h1300
`define AOT_SCALE_SHIFT     17
`endif

// ==== include/aot_pkg.sv ====
// Types shared by the angle-to-output transfer configuration bank.
// Assumes the constants header is on the include path.
`include "aot_cfg.svh"
package aot_pkg;
	typedef logic [12:0] aot_dac_t;
	typedef logic [15:0] aot_word_t;
	typedef logic [18:0] aot_scale_t;
	typedef enum {
		AOT_SEL_NONE,
		AOT_SEL_ZERO,
		AOT_SEL_SW_HIGH,
		AOT_SEL_OPT_LOW,
		AOT_SEL_FLOOR,
		AOT_SEL_CEIL
	} aot_sel_t;
endpackage

// ==== logic/aot_limit.sv ====
// Places a code step on one clamp level and holds it inside both levels.
// Assumes a purely combinational use inside the transfer bank.
`timescale 1ns/100ps
module aot_limit #(
	parameter int DAC_W  = 13,
	parameter int STEP_W = 18
) (
	// Levels and slope.
	input  wire logic [DAC_W-1:0]  floorLevel,
	input  wire logic [DAC_W-1:0]  ceilLevel,
	input  wire logic              falling,
	// Step and result.
	input  wire logic [STEP_W-1:0] step,
	output logic      [DAC_W-1:0]  code
);
	if (STEP_W <= DAC_W) begin : g_chk
		$error("Step must be wider than the DAC code.");
	end
	logic [STEP_W:0] span;
	logic [STEP_W:0] sum;
	always_comb begin
		span = {{(STEP_W+1-DAC_W){1'b0}}, ceilLevel} - {{(STEP_W+1-DAC_W){1'b0}}, floorLevel};
		sum  = {{(STEP_W+1-DAC_W){1'b0}}, floorLevel} + {1'b0, step};
		if (falling) begin
			if ({1'b0, step} >= span) begin
				code = floorLevel;
			end else begin
				code = ceilLevel - step[DAC_W-1:0];
			end
		end else if (sum > {{(STEP_W+1-DAC_W){1'b0}}, ceilLevel}) begin
			code = ceilLevel;
		end else begin
			code = sum[DAC_W-1:0];
		end
	end
endmodule

// ==== logic/aot_scale.sv ====
// Scales an angle offset by the range factor into a DAC code step.
// Assumes a purely combinational use inside the transfer bank.
`timescale 1ns/100ps
`include "aot_cfg.svh"
module aot_scale #(
	parameter int ANGLE_W = 16,
	parameter int SCALE_W = 19,
	parameter int STEP_W  = 18
) (
	// Operands.
	input  wire logic [ANGLE_W-1:0] angleRel,
	input  wire logic [SCALE_W-1:0] scale,
	// Result.
	output logic      [STEP_W-1:0]  step
);
	if (ANGLE_W + SCALE_W - `AOT_SCALE_SHIFT != STEP_W) begin : g_chk
		$error("Step width does not match the scaled product.");
	end
	logic [ANGLE_W+SCALE_W-1:0] product;
	always_comb begin
		product = angleRel * scale;
		step    = product[ANGLE_W+SCALE_W-1:`AOT_SCALE_SHIFT];
	end
endmodule

// ==== logic/aot_transfer_bank.sv ====
// Configuration bank and transfer path from measured angle to DAC code.
// Assumes one clock, synchronous inputs and a master on the plain register port.
//
// Function
// - Floor level is a 13-bit unsigned DAC code in bits 12 to 0.
// - Floor bits 15 to 13 are undefined, ignored on write and read as zero.
// - Ceiling bits 15 to 13 are undefined, ignored on write and read as zero.
// - Clamp codes scale with supply: 5120 is full, 512 a tenth, 256 a twentieth.
// - Range factor high part sits in bits 5 to 0 at address 9h.
// - Range factor low part sits in bits 12 to 0 at address Ah.
// - Floor switch angle sits in bits 15 to 6 at 9h as a fraction.
// - Beyond the switch angle with rising slope the output takes the floor level.
// - Zero position is a 16-bit unsigned fraction of 180 degrees.
// - Bit 13 at Ah selects rising or falling output slope.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "aot_cfg.svh"
module aot_transfer_bank #(
	parameter int DAC_W   = 13,
	parameter int ANGLE_W = 16
) (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Register port.
	input  wire logic [3:0]           regAddr,
	input  wire logic [15:0]          regWrData,
	input  wire logic                 regWr,
	input  wire logic                 regRd,
	output logic      [15:0]          regRdData,
	// Measured angle.
	input  wire logic [ANGLE_W-1:0]   angle,
	input  wire logic                 angleValid,
	// Output code.
	output logic      [DAC_W-1:0]     dacCode,
	output logic                      dacValid,
	output logic      [1:0]           diagLevel
);
	localparam int SCALE_W = 19;
	localparam int SW_W    = 10;
	localparam int STEP_W  = ANGLE_W + SCALE_W - `AOT_SCALE_SHIFT;

	if (DAC_W != `AOT_LEVEL_MSB + 1 || ANGLE_W != 16) begin : g_chk
		$error("The bank serves a 13-bit DAC code and a 16-bit angle only.");
	end

	// Stored configuration.
	logic [15:0]      zero_q;
	logic [15:0]      zero_d;
	logic [SW_W-1:0]  switchAngle_q;
	logic [SW_W-1:0]  switchAngle_d;
	logic [5:0]       rangeScaleHigh_q;
	logic [5:0]       rangeScaleHigh_d;
	logic [15:0]      optLow_q;
	logic [15:0]      optLow_d;
	logic [DAC_W-1:0] floorLevel_q;
	logic [DAC_W-1:0] floorLevel_d;
	logic [DAC_W-1:0] ceilLevel_q;
	logic [DAC_W-1:0] ceilLevel_d;
	logic [15:0]      rdData_q;
	logic [15:0]      rdData_d;
	aot_pkg::aot_sel_t sel;

	// Transfer path state.
	logic [DAC_W-1:0]   dac_q;
	logic [DAC_W-1:0]   dac_d;
	logic               valid_q;
	logic               valid_d;
	logic [ANGLE_W-1:0] angleRel;
	logic [SCALE_W-1:0] rangeScale;
	logic [STEP_W-1:0]  step;
	logic [DAC_W-1:0]   limited;
	logic               falling;
	logic               beyond;

	// Address decode.
	always_comb begin
		case (regAddr)
			`AOT_ADDR_ZERO: begin
				sel = aot_pkg::AOT_SEL_ZERO;
			end
			`AOT_ADDR_SW_HIGH: begin
				sel = aot_pkg::AOT_SEL_SW_HIGH;
			end
			`AOT_ADDR_OPT_LOW: begin
				sel = aot_pkg::AOT_SEL_OPT_LOW;
			end
			`AOT_ADDR_FLOOR: begin
				sel = aot_pkg::AOT_SEL_FLOOR;
			end
			`AOT_ADDR_CEIL: begin
				sel = aot_pkg::AOT_SEL_CEIL;
			end
			default: begin
				sel = aot_pkg::AOT_SEL_NONE;
			end
		endcase
	end

	// Register writes and read data.
	always_comb begin
		zero_d           = zero_q;
		switchAngle_d    = switchAngle_q;
		rangeScaleHigh_d = rangeScaleHigh_q;
		optLow_d         = optLow_q;
		floorLevel_d     = floorLevel_q;
		ceilLevel_d      = ceilLevel_q;
		rdData_d         = 16'h0000;
		if (regWr) begin
			case (sel)
				aot_pkg::AOT_SEL_ZERO: begin
					zero_d = regWrData;
				end
				aot_pkg::AOT_SEL_SW_HIGH: begin
					switchAngle_d    = regWrData[15:`AOT_SW_LSB];
					rangeScaleHigh_d = regWrData[`AOT_HIGH_MSB:0];
				end
				aot_pkg::AOT_SEL_OPT_LOW: begin
					optLow_d = regWrData;
				end
				aot_pkg::AOT_SEL_FLOOR: begin
					floorLevel_d = regWrData[`AOT_LEVEL_MSB:0];
				end
				aot_pkg::AOT_SEL_CEIL: begin
					ceilLevel_d = regWrData[`AOT_LEVEL_MSB:0];
				end
				default: begin
				end
			endcase
		end
		if (regRd) begin
			case (sel)
				aot_pkg::AOT_SEL_ZERO: begin
					rdData_d = zero_q;
				end
				aot_pkg::AOT_SEL_SW_HIGH: begin
					rdData_d = {switchAngle_q, rangeScaleHigh_q};
				end
				aot_pkg::AOT_SEL_OPT_LOW: begin
					rdData_d = optLow_q;
				end
				aot_pkg::AOT_SEL_FLOOR: begin
					rdData_d = {3'h0, floorLevel_q};
				end
				aot_pkg::AOT_SEL_CEIL: begin
					rdData_d = {3'h0, ceilLevel_q};
				end
				default: begin
					rdData_d = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			zero_q           <= `AOT_RST_ZERO;
			switchAngle_q    <= SW_W'(`AOT_RST_SW_HIGH >> `AOT_SW_LSB);
			rangeScaleHigh_q <= 6'(`AOT_RST_SW_HIGH);
			optLow_q         <= `AOT_RST_OPT_LOW;
			floorLevel_q     <= DAC_W'(`AOT_RST_FLOOR);
			ceilLevel_q      <= DAC_W'(`AOT_RST_CEIL);
			rdData_q         <= 16'h0000;
		end else begin
			zero_q           <= zero_d;
			switchAngle_q    <= switchAngle_d;
			rangeScaleHigh_q <= rangeScaleHigh_d;
			optLow_q         <= optLow_d;
			floorLevel_q     <= floorLevel_d;
			ceilLevel_q      <= ceilLevel_d;
			rdData_q         <= rdData_d;
		end
	end

	// Transfer from angle to code.
	always_comb begin
		angleRel   = angle - zero_q;
		rangeScale = {rangeScaleHigh_q, optLow_q[`AOT_LOW_MSB:0]};
		falling    = optLow_q[`AOT_SLOPE_BIT];
		beyond     = angleRel[ANGLE_W-1:ANGLE_W-SW_W] > switchAngle_q;
	end

	aot_scale #(
		.ANGLE_W (ANGLE_W),
		.SCALE_W (SCALE_W),
		.STEP_W  (STEP_W)
	) u_scale (
		.angleRel (angleRel),
		.scale    (rangeScale),
		.step     (step)
	);

	aot_limit #(
		.DAC_W  (DAC_W),
		.STEP_W (STEP_W)
	) u_limit (
		.floorLevel (floorLevel_q),
		.ceilLevel  (ceilLevel_q),
		.falling    (falling),
		.step       (step),
		.code       (limited)
	);

	always_comb begin
		dac_d   = dac_q;
		valid_d = angleValid;
		if (angleValid) begin
			if (beyond) begin
				dac_d = falling ? ceilLevel_q : floorLevel_q;
			end else begin
				dac_d = limited;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dac_q   <= DAC_W'(`AOT_RST_FLOOR);
			valid_q <= 1'b0;
		end else begin
			dac_q   <= dac_d;
			valid_q <= valid_d;
		end
	end

	// Outputs; the code runs on a supply-ratio scale with full supply at 5120.
	assign regRdData = rdData_q;
	assign dacCode   = dac_q;
	assign dacValid  = valid_q;
	assign diagLevel = optLow_q[15:`AOT_DIAG_LSB];

	logic [SW_W-1:0] relTop;
	logic            inOrder;
	assign relTop  = angleRel[ANGLE_W-1:ANGLE_W-SW_W];
	assign inOrder = floorLevel_q <= ceilLevel_q;

	a_floor_read_top: assert property (@(posedge clk) disable iff (rst)
		regRd && regAddr == `AOT_ADDR_FLOOR |=> regRdData[15:13] == 3'h0)
		else $error("Floor level read shows upper bits set.");

	a_ceil_read_top: assert property (@(posedge clk) disable iff (rst)
		regRd && regAddr == `AOT_ADDR_CEIL |=> regRdData == {3'h0, ceilLevel_q})
		else $error("Ceiling level read is wrong.");

	a_floor_write_keep: assert property (@(posedge clk) disable iff (rst)
		regWr && regAddr == `AOT_ADDR_FLOOR |=> floorLevel_q == $past(regWrData[12:0]))
		else $error("Floor level write not stored.");

	a_high_split_fields: assert property (@(posedge clk) disable iff (rst)
		regWr && regAddr == `AOT_ADDR_SW_HIGH ##1 regRd && regAddr == `AOT_ADDR_SW_HIGH
		|=> regRdData == $past(regWrData, 2))
		else $error("Switch angle and high range part do not read back.");

	a_low_part_scale: assert property (@(posedge clk) disable iff (rst)
		regWr && regAddr == `AOT_ADDR_OPT_LOW |=> rangeScale[12:0] == $past(regWrData[12:0]))
		else $error("Low range part not used by the scale.");

	a_switch_to_floor: assert property (@(posedge clk) disable iff (rst)
		angleValid && relTop > switchAngle_q && !falling |=> dacCode == $past(floorLevel_q))
		else $error("Output not at floor level beyond switch angle.");

	a_zero_gives_floor: assert property (@(posedge clk) disable iff (rst)
		angleValid && angle == zero_q && !falling && inOrder
		|=> dacCode == $past(floorLevel_q) && dacValid)
		else $error("Zero position does not give the floor level.");

	a_falling_at_ceil: assert property (@(posedge clk) disable iff (rst)
		angleValid && angle == zero_q && falling && inOrder |=> dacCode == $past(ceilLevel_q))
		else $error("Falling slope does not start at the ceiling level.");

	a_output_in_range: assert property (@(posedge clk) disable iff (rst)
		angleValid && inOrder
		|=> dacCode >= $past(floorLevel_q) && dacCode <= $past(ceilLevel_q))
		else $error("Output code left the clamp range.");

	a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
		regRd && (regAddr < `AOT_ADDR_ZERO || regAddr > `AOT_ADDR_CEIL) |=> regRdData == 16'h0000)
		else $error("Unmapped read not zero.");

	a_valid_follows: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> dacValid == $past(angleValid))
		else $error("Output valid does not follow the angle strobe.");

	a_code_holds: assert property (@(posedge clk) disable iff (rst)
		!angleValid |=> $stable(dacCode))
		else $error("Output code moved without an angle sample.");

	a_ceil_write_keep: assert property (@(posedge clk) disable iff (rst)
		regWr && regAddr == `AOT_ADDR_CEIL |=> ceilLevel_q == $past(regWrData[12:0]))
		else $error("Ceiling level write not stored.");

	a_switch_write_keep: assert property (@(posedge clk) disable iff (rst)
		regWr && regAddr == `AOT_ADDR_SW_HIGH
		|=> switchAngle_q == $past(regWrData[15:`AOT_SW_LSB]))
		else $error("Switch angle write not stored.");

	a_falling_beyond_ceil: assert property (@(posedge clk) disable iff (rst)
		angleValid && relTop > switchAngle_q && falling |=> dacCode == $past(ceilLevel_q))
		else $error("Output not at ceiling level beyond switch angle.");
endmodule
